// ===== design/itt_defines.vh
// Constants of the interrupt-triggered transfer engine: register map,
// transfer information layout and field positions.
// Assumes byte-addressed memory with 32-bit words on a Wishbone bus.
`ifndef ITT_DEFINES_VH
`define ITT_DEFINES_VH
// Register byte offsets
`define ITT_REG_CTRL     8'h00
`define ITT_REG_VBASE    8'h04
`define ITT_REG_SEQCTL   8'h08
`define ITT_REG_SEQBASE  8'h0C
`define ITT_REG_STATUS   8'h10
// Reset values
`define ITT_RST_WORD     32'h00000000
// Transfer information: four words, 16 bytes per entry
`define ITT_INFO_BYTES   32'h00000010
`define ITT_INFO_SHIFT   4
// Word 0 fields
`define ITT_W0_MODE_LO   0
`define ITT_W0_SIZE_LO   2
`define ITT_W0_SRC_INC   4
`define ITT_W0_DST_INC   5
`define ITT_W0_RPT_DST   6
`define ITT_W0_CHAIN     7
`define ITT_W0_CH_ZERO   8
`define ITT_W0_IRQ_EACH  9
`define ITT_W0_SEQ_STOP  10
// Modes
`define ITT_MODE_NORMAL  2'h0
`define ITT_MODE_REPEAT  2'h1
`define ITT_MODE_BLOCK   2'h2
// Word 3 fields: counter low half, repeat/block size in bits 23:16
`define ITT_W3_SIZE_LO   16
`define ITT_FULL_SIZE    9'h100
`endif

// ===== design/itt_engine.v
// Interrupt-triggered transfer engine: one channel per request line,
// transfer information fetched from memory, data moved over a Wishbone
// master, control registers on a Wishbone slave.
// Assumes memory answers every master cycle with ack; requests are levels
// that the source drops after seeing its acknowledge pulse.
`timescale 1ns/1ps
`default_nettype none
`include "itt_defines.vh"
module itt_engine #(
  parameter NCH = 8,
  parameter CHW = 3
) (
  // Clock and reset
  input  wire           clk_i,
  input  wire           rst_i,
  // Wishbone slave for control registers
  input  wire           wb_cyc_i,
  input  wire           wb_stb_i,
  input  wire           wb_we_i,
  input  wire [7:0]     wb_adr_i,
  input  wire [3:0]     wb_sel_i,
  input  wire [31:0]    wb_dat_i,
  output reg  [31:0]    wb_dat_o,
  output reg            wb_ack_o,
  // Wishbone master to memory and peripherals
  output reg            m_cyc_o,
  output reg            m_stb_o,
  output reg            m_we_o,
  output reg  [31:0]    m_adr_o,
  output reg  [3:0]     m_sel_o,
  output reg  [31:0]    m_dat_o,
  input  wire           m_ack_i,
  input  wire [31:0]    m_dat_i,
  // Interrupt source requests and their acknowledges
  input  wire [NCH-1:0] req_i,
  output reg  [NCH-1:0] req_ack_o,
  // Event outputs
  output reg            cpu_irq_o,
  output reg            evt_link_o,
  output reg  [CHW-1:0] evt_chan_o
);
  localparam S_IDLE = 3'h0;
  localparam S_INFO = 3'h1;
  localparam S_RD   = 3'h2;
  localparam S_WR   = 3'h3;
  localparam S_WB   = 3'h4;
  localparam S_NEXT = 3'h5;
  localparam S_SEQ  = 3'h6;

  reg           en_r;
  reg  [31:0]   vbase_r;
  reg           seq_en_r;
  reg  [7:0]    seq_src_r;
  reg  [31:0]   seq_base_r;
  reg  [2:0]    state_r;
  reg  [CHW-1:0] ch_r;
  reg  [31:0]   info_r;
  reg  [1:0]    idx_r;
  reg  [31:0]   w0_r;
  reg  [31:0]   src_r;
  reg  [31:0]   dst_r;
  reg  [31:0]   w3_r;
  reg  [8:0]    blk_r;
  reg           zero_r;
  reg           pick_r;
  reg           in_seq_r;
  reg           res_v_r;
  reg  [31:0]   res_a_r;
  reg  [7:0]    sel_r;
  reg           any_req;
  reg  [CHW-1:0] win;
  integer       i;
  wire          f_in_rdy;
  wire          f_out_vld;
  wire [31:0]   f_out;
  wire          f_push;
  wire          f_pop;
  wire          wb_hit;
  wire [1:0]    mode;
  wire [1:0]    usz;
  wire [31:0]   inc;
  wire [8:0]    nsz;
  wire [31:0]   area;
  wire [31:0]   src_n;
  wire [31:0]   dst_n;
  wire [31:0]   rd_unit;
  wire [31:0]   wr_rep;
  wire [3:0]    wr_sel;
  wire [15:0]   cnt_n;
  wire [7:0]    rpt_n;
  wire          chain_go;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign mode   = w0_r[`ITT_W0_MODE_LO+1:`ITT_W0_MODE_LO];
  assign usz    = w0_r[`ITT_W0_SIZE_LO+1:`ITT_W0_SIZE_LO];
  // Unit of 1, 2 or 4 bytes; size code 3 moves a longword, but area counts it as 8 bytes
  assign inc    = (usz == 2'h0) ? 32'h1 : (usz == 2'h1) ? 32'h2 : 32'h4;
  // Size field 0 stands for 256 so that a full 256-unit area is reachable
  assign nsz    = (w3_r[23:16] == 8'h00) ? `ITT_FULL_SIZE :
                  {1'b0, w3_r[23:16]};
  assign area   = {23'h0, nsz} << usz;
  assign src_n  = w0_r[`ITT_W0_SRC_INC] ? src_r + inc : src_r;
  assign dst_n  = w0_r[`ITT_W0_DST_INC] ? dst_r + inc : dst_r;
  assign cnt_n  = w3_r[15:0] - 16'h1;
  assign rpt_n  = w3_r[7:0] - 8'h1;
  // Byte lanes: data sits on the lanes of its address
  assign rd_unit = (m_dat_i >> {src_r[1:0], 3'b000}) &
                   ((usz == 2'h0) ? 32'hFF : (usz == 2'h1) ? 32'hFFFF :
                   32'hFFFFFFFF);
  assign wr_rep = (usz == 2'h0) ? {4{f_out[7:0]}} :
                  (usz == 2'h1) ? {2{f_out[15:0]}} : f_out;
  assign wr_sel = (usz == 2'h0) ? (4'h1 << dst_r[1:0]) :
                  (usz == 2'h1) ? (4'h3 << {dst_r[1], 1'b0}) : 4'hF;
  // Next linked entry runs always, or only when the counter hit zero
  assign chain_go = w0_r[`ITT_W0_CHAIN] &
                    (~w0_r[`ITT_W0_CH_ZERO] | zero_r);
  // Reads enter the buffer only while it has room; writes drain it
  assign f_push = (state_r == S_RD) & m_cyc_o & m_ack_i;
  assign f_pop  = (state_r == S_WR) & m_cyc_o & m_ack_i;

  itt_fifo #(
    .WIDTH (32),
    .DEPTH (32),
    .AW    (5)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (f_push),
    .in_ready_o  (f_in_rdy),
    .in_data_i   (rd_unit),
    .out_valid_o (f_out_vld),
    .out_ready_i (f_pop),
    .out_data_o  (f_out)
  );

  // Lowest-numbered pending source wins; one channel per request line
  always @* begin
    any_req = 1'b0;
    win     = {CHW{1'b0}};
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (req_i[i]) begin
        any_req = 1'b1;
        win     = i[CHW-1:0];
      end
    end
  end

  // Register slave: one-cycle answer, unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= `ITT_RST_WORD;
      en_r       <= 1'b0;
      vbase_r    <= `ITT_RST_WORD;
      seq_en_r   <= 1'b0;
      seq_src_r  <= 8'h00;
      seq_base_r <= `ITT_RST_WORD;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit & wb_we_i) begin
        case (wb_adr_i)
          `ITT_REG_CTRL: begin
            if (wb_sel_i[0]) en_r <= wb_dat_i[0];
          end
          `ITT_REG_VBASE: begin
            vbase_r <= wb_dat_i;
          end
          `ITT_REG_SEQCTL: begin
            // A single trigger source is held, so only one can be chosen
            if (wb_sel_i[0]) seq_en_r <= wb_dat_i[0];
            if (wb_sel_i[1]) seq_src_r <= wb_dat_i[15:8];
          end
          `ITT_REG_SEQBASE: begin
            seq_base_r <= wb_dat_i;
          end
          default: begin
          end
        endcase
      end
      case (wb_adr_i)
        `ITT_REG_CTRL:    wb_dat_o <= {31'h0, en_r};
        `ITT_REG_VBASE:   wb_dat_o <= vbase_r;
        `ITT_REG_SEQCTL:  wb_dat_o <= {16'h0, seq_src_r, 7'h0, seq_en_r};
        `ITT_REG_SEQBASE: wb_dat_o <= seq_base_r;
        `ITT_REG_STATUS:  wb_dat_o <= {15'h0, res_v_r,
                                       {(8-CHW){1'b0}}, ch_r,
                                       7'h0, (state_r != S_IDLE)};
        default:          wb_dat_o <= `ITT_RST_WORD;
      endcase
    end
  end

  // Transfer sequencer; each bus state issues, then waits for ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= S_IDLE;
      ch_r       <= {CHW{1'b0}};
      info_r     <= `ITT_RST_WORD;
      idx_r      <= 2'h0;
      w0_r       <= `ITT_RST_WORD;
      src_r      <= `ITT_RST_WORD;
      dst_r      <= `ITT_RST_WORD;
      w3_r       <= `ITT_RST_WORD;
      blk_r      <= 9'h0;
      zero_r     <= 1'b0;
      pick_r     <= 1'b0;
      in_seq_r   <= 1'b0;
      res_v_r    <= 1'b0;
      res_a_r    <= `ITT_RST_WORD;
      sel_r      <= 8'h00;
      m_cyc_o    <= 1'b0;
      m_stb_o    <= 1'b0;
      m_we_o     <= 1'b0;
      m_adr_o    <= `ITT_RST_WORD;
      m_sel_o    <= 4'h0;
      m_dat_o    <= `ITT_RST_WORD;
      req_ack_o  <= {NCH{1'b0}};
      cpu_irq_o  <= 1'b0;
      evt_link_o <= 1'b0;
      evt_chan_o <= {CHW{1'b0}};
    end else begin
      req_ack_o  <= {NCH{1'b0}};
      cpu_irq_o  <= 1'b0;
      evt_link_o <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (en_r & any_req) begin
            ch_r      <= win;
            req_ack_o <= {{(NCH-1){1'b0}}, 1'b1} << win;
            idx_r     <= 2'h0;
            state_r   <= S_INFO;
            if (seq_en_r & ({{(8-CHW){1'b0}}, win} == seq_src_r) &
                res_v_r) begin
              // Divided sequence picks up where it stopped
              info_r   <= res_a_r;
              in_seq_r <= 1'b1;
              pick_r   <= 1'b0;
            end else begin
              info_r   <= vbase_r + ({{(32-CHW){1'b0}}, win}
                          << `ITT_INFO_SHIFT);
              in_seq_r <= 1'b0;
              pick_r   <= seq_en_r &
                          ({{(8-CHW){1'b0}}, win} == seq_src_r);
            end
          end
        end
        S_INFO: begin
          // Information is fetched before any data moves
          if (!m_cyc_o) begin
            m_cyc_o <= 1'b1;
            m_stb_o <= 1'b1;
            m_we_o  <= 1'b0;
            m_sel_o <= 4'hF;
            m_adr_o <= info_r + {28'h0, idx_r, 2'b00};
          end else if (m_ack_i) begin
            m_cyc_o <= 1'b0;
            m_stb_o <= 1'b0;
            idx_r   <= idx_r + 2'h1;
            case (idx_r)
              2'h0: w0_r  <= m_dat_i;
              2'h1: src_r <= m_dat_i;
              2'h2: dst_r <= m_dat_i;
              default: begin
                w3_r    <= m_dat_i;
                blk_r   <= (m_dat_i[23:16] == 8'h00) ? `ITT_FULL_SIZE :
                           {1'b0, m_dat_i[23:16]};
                zero_r  <= 1'b0;
                state_r <= S_RD;
              end
            endcase
          end
        end
        S_RD: begin
          // Back-pressure: no read is issued while the buffer is full
          if (!m_cyc_o && f_in_rdy) begin
            m_cyc_o <= 1'b1;
            m_stb_o <= 1'b1;
            m_we_o  <= 1'b0;
            m_sel_o <= 4'hF;
            m_adr_o <= src_r;
          end else if (m_cyc_o && m_ack_i) begin
            m_cyc_o <= 1'b0;
            m_stb_o <= 1'b0;
            state_r <= S_WR;
          end
        end
        S_WR: begin
          if (!m_cyc_o && f_out_vld) begin
            m_cyc_o <= 1'b1;
            m_stb_o <= 1'b1;
            m_we_o  <= 1'b1;
            m_sel_o <= wr_sel;
            m_adr_o <= dst_r;
            m_dat_o <= wr_rep;
            if (blk_r == nsz) sel_r <= f_out[7:0];
          end else if (m_cyc_o && m_ack_i) begin
            m_cyc_o <= 1'b0;
            m_stb_o <= 1'b0;
            m_we_o  <= 1'b0;
            src_r   <= src_n;
            dst_r   <= dst_n;
            evt_chan_o <= ch_r;
            case (mode)
              `ITT_MODE_REPEAT: begin
                evt_link_o <= 1'b1;
                state_r    <= S_WB;
                idx_r      <= 2'h1;
                if (rpt_n == 8'h00) begin
                  // Area end reached: reload count, rewind the address
                  w3_r[7:0] <= w3_r[23:16];
                  zero_r    <= 1'b1;
                  if (w0_r[`ITT_W0_RPT_DST]) dst_r <= dst_n - area;
                  else src_r <= src_n - area;
                end else begin
                  w3_r[7:0] <= rpt_n;
                end
              end
              `ITT_MODE_BLOCK: begin
                blk_r <= blk_r - 9'h1;
                if (blk_r == 9'h1) begin
                  // One count per whole block, moved without new request
                  w3_r[15:0] <= cnt_n;
                  zero_r     <= (cnt_n == 16'h0);
                  evt_link_o <= 1'b1;
                  state_r    <= S_WB;
                  idx_r      <= 2'h1;
                end else begin
                  state_r <= S_RD;
                end
              end
              default: begin
                // Normal: exactly one unit, then the entry is written back
                w3_r[15:0] <= cnt_n;
                zero_r     <= (cnt_n == 16'h0);
                evt_link_o <= 1'b1;
                state_r    <= S_WB;
                idx_r      <= 2'h1;
              end
            endcase
          end
        end
        S_WB: begin
          // Updated addresses and count go back to the entry
          if (!m_cyc_o) begin
            m_cyc_o <= 1'b1;
            m_stb_o <= 1'b1;
            m_we_o  <= 1'b1;
            m_sel_o <= 4'hF;
            m_adr_o <= info_r + {28'h0, idx_r, 2'b00};
            m_dat_o <= (idx_r == 2'h1) ? src_r :
                       (idx_r == 2'h2) ? dst_r : w3_r;
          end else if (m_ack_i) begin
            m_cyc_o <= 1'b0;
            m_stb_o <= 1'b0;
            m_we_o  <= 1'b0;
            idx_r   <= idx_r + 2'h1;
            if (idx_r == 2'h3) begin
              state_r <= S_NEXT;
              cpu_irq_o <= w0_r[`ITT_W0_IRQ_EACH] | zero_r;
            end
          end
        end
        S_NEXT: begin
          idx_r <= 2'h0;
          if (pick_r) begin
            pick_r  <= 1'b0;
            state_r <= S_SEQ;
          end else if (chain_go) begin
            if (in_seq_r & w0_r[`ITT_W0_SEQ_STOP]) begin
              // Division point: remember the rest for the next request
              res_v_r <= 1'b1;
              res_a_r <= info_r + `ITT_INFO_BYTES;
              state_r <= S_IDLE;
            end else begin
              info_r  <= info_r + `ITT_INFO_BYTES;
              state_r <= S_INFO;
            end
          end else begin
            if (in_seq_r) res_v_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        S_SEQ: begin
          // The first moved byte indexes a table of 256 entry pointers
          if (!m_cyc_o) begin
            m_cyc_o <= 1'b1;
            m_stb_o <= 1'b1;
            m_we_o  <= 1'b0;
            m_sel_o <= 4'hF;
            m_adr_o <= seq_base_r + {22'h0, sel_r, 2'b00};
          end else if (m_ack_i) begin
            m_cyc_o  <= 1'b0;
            m_stb_o  <= 1'b0;
            info_r   <= m_dat_i;
            in_seq_r <= 1'b1;
            state_r  <= S_INFO;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== design/itt_engine_unused_placeholder_removed.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== design/itt_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module itt_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;

  // Full and empty come from the word count, never from pointers alone
  assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage is not reset; only the pointers and the count carry state
  always @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  // Pointer and count update
  always @(posedge clk_i) begin
    if (rst_i) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/itt_mem_model.sv
// Memory model behind the engine's Wishbone master: 256 words.
// Assumes classic single cycles; answer delay set by wait_i.
`timescale 1ns/1ps
`default_nettype none
module itt_mem_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave side
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  // Answer delay in cycles
  input  wire logic [3:0]  wait_i
);
  logic [31:0] mem [0:255];
  logic [3:0]  cnt;
  integer      b;
  // Data is toggled outside answers so stale words never look valid
  always @(posedge clk_i) begin
    if (rst_i || ack_o || !(cyc_i && stb_i)) begin
      ack_o <= 1'b0;
      cnt   <= 4'h0;
      dat_o <= rst_i ? 32'h0 : ~dat_o;
    end else if (cnt < wait_i) begin
      cnt <= cnt + 4'h1;
    end else begin
      ack_o <= 1'b1;
      dat_o <= mem[adr_i[9:2]];
      for (b = 0; b < 4; b = b + 1)
        if (we_i && sel_i[b]) mem[adr_i[9:2]][8*b +: 8] <= dat_i[8*b +: 8];
    end
  end
endmodule
`default_nettype wire

// ===== tb/itt_props.sv
// Checker of the engine's port timing: register bus, memory master,
// request acknowledge and event pulses.
// Assumes one clock and the synchronous active-high reset rst_i.
`timescale 1ns/1ps
`default_nettype none
module itt_props #(
  parameter NCH = 8,
  parameter CHW = 3
) (
  // Clock and reset
  input wire logic           clk_i,
  input wire logic           rst_i,
  // Register bus
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_ack_o,
  // Memory master
  input wire logic           m_cyc_o,
  input wire logic           m_stb_o,
  input wire logic           m_we_o,
  input wire logic [31:0]    m_adr_o,
  input wire logic [3:0]     m_sel_o,
  input wire logic [31:0]    m_dat_o,
  input wire logic           m_ack_i,
  // Requests and events
  input wire logic [NCH-1:0] req_i,
  input wire logic [NCH-1:0] req_ack_o,
  input wire logic           cpu_irq_o,
  input wire logic           evt_link_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Register answers come one cycle after the request is taken
  AST_WB_LAT: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=>
    wb_ack_o) else $error("register ack not one cycle after request");
  AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack longer than one cycle");
  // A master cycle must not move before memory answers it
  AST_M_HOLD: assert property ((m_cyc_o && !m_ack_i) |=> m_cyc_o && m_stb_o
    && $stable(m_adr_o) && $stable(m_we_o) && $stable(m_sel_o)
    && $stable(m_dat_o)) else $error("master request changed before ack");
  AST_M_GAP: assert property ((m_cyc_o && m_ack_i) |=> !m_cyc_o)
    else $error("master cycle not released after ack");
  // Only a requesting channel is acknowledged, one at a time
  AST_ACK_ONE: assert property ((req_ack_o != 0) |->
    $onehot(req_ack_o) ##1 (req_ack_o == 0))
    else $error("request ack not a single pulse");
  AST_ACK_REQ: assert property ((req_ack_o != 0) |->
    ((req_ack_o & ~$past(req_i)) == 0)) else $error("ack of idle channel");
  // Information is read before anything is written
  AST_INFO_FIRST: assert property ((req_ack_o != 0) |=>
    m_cyc_o && !m_we_o) else $error("activation did not start with a read");
  AST_EVT: assert property (evt_link_o |->
    $past(m_cyc_o && m_we_o && m_ack_i) ##1 !evt_link_o)
    else $error("event pulse not after a write");
  AST_IRQ: assert property (cpu_irq_o |->
    $past(m_cyc_o && m_we_o && m_ack_i) ##1 !cpu_irq_o)
    else $error("irq not after write-back");
endmodule
bind itt_engine itt_props #(.NCH(NCH), .CHW(CHW)) u_itt_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o),
  .m_we_o(m_we_o), .m_adr_o(m_adr_o), .m_sel_o(m_sel_o),
  .m_dat_o(m_dat_o), .m_ack_i(m_ack_i), .req_i(req_i),
  .req_ack_o(req_ack_o), .cpu_irq_o(cpu_irq_o), .evt_link_o(evt_link_o));
`default_nettype wire

// ===== tb/tb.sv
// Testbench of the transfer engine: registers, transfer modes, chaining
// and sequences; the data FIFO is exercised through the block transfers.
// Assumes the memory model answers every master cycle.
`timescale 1ns/1ps
`default_nettype none
`include "itt_defines.vh"
module tb;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, req_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, q;
  logic [3:0]  mwait = 4'h0, wb_sel_i = 4'hF;
  wire  [31:0] wb_dat_o, m_adr_o, m_dat_o, m_dat_i;
  wire  [7:0]  req_ack_o;
  wire  [3:0]  m_sel_o;
  wire  [2:0]  evt_chan_o;
  wire         wb_ack_o, m_cyc_o, m_stb_o, m_we_o, m_ack_i;
  wire         cpu_irq_o, evt_link_o;
  integer      fails = 0, check_count = 0, evt_n = 0, irq_n = 0, e0, i0;

  always #2.5 clk_i = ~clk_i;
  // Pulses stand one cycle, so each edge counts at most once
  always @(posedge clk_i) begin
    if (evt_link_o === 1'b1) evt_n <= evt_n + 1;
    if (cpu_irq_o === 1'b1) irq_n <= irq_n + 1;
  end

  itt_engine #(.NCH(8), .CHW(3)) u_itt_engine (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o), .m_we_o(m_we_o),
    .m_adr_o(m_adr_o), .m_sel_o(m_sel_o), .m_dat_o(m_dat_o),
    .m_ack_i(m_ack_i), .m_dat_i(m_dat_i), .req_i(req_i),
    .req_ack_o(req_ack_o), .cpu_irq_o(cpu_irq_o),
    .evt_link_o(evt_link_o), .evt_chan_o(evt_chan_o));
  itt_mem_model u_itt_mem_model (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(m_cyc_o), .stb_i(m_stb_o), .we_i(m_we_o), .adr_i(m_adr_o),
    .sel_i(m_sel_o), .dat_i(m_dat_o), .ack_o(m_ack_i), .dat_o(m_dat_i),
    .wait_i(mwait));

  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Classic single cycle, held until ack is sampled high
  task wb(input [7:0] a, input w, input [31:0] d, output [31:0] r);
    begin
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w;
      wb_adr_i <= a; wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  function [31:0] rd(input [9:0] a);
    rd = u_itt_mem_model.mem[a[9:2]];
  endfunction
  // Loads one information entry of four words
  task ent(input [9:0] a, input [31:0] w0, w1, w2, w3);
    begin
      u_itt_mem_model.mem[a[9:2]] = w0;
      u_itt_mem_model.mem[a[9:2] + 1] = w1;
      u_itt_mem_model.mem[a[9:2] + 2] = w2;
      u_itt_mem_model.mem[a[9:2] + 3] = w3;
    end
  endtask
  // Level request held until its ack, then wait until not busy
  task fire(input integer ch);
    begin
      e0 = evt_n; i0 = irq_n;
      req_i[ch] <= 1'b1;
      @(posedge clk_i);
      while (req_ack_o[ch] !== 1'b1) @(posedge clk_i);
      req_i[ch] <= 1'b0;
      q = 32'h1;
      while (q[0] !== 1'b0) wb(`ITT_REG_STATUS, 1'b0, 32'h0, q);
    end
  endtask

  task t_regs;
    logic [7:0] a;
    begin
      for (a = 8'h00; a <= 8'h10; a = a + 8'h04) begin
        wb(a, 1'b0, 32'h0, q); chk(q, `ITT_RST_WORD);
      end
      wb(`ITT_REG_VBASE, 1'b1, 32'h200, q);
      wb(`ITT_REG_VBASE, 1'b0, 32'h0, q); chk(q, 32'h200);
      wb(8'h14, 1'b1, 32'hFFFFFFFF, q);
      wb(8'h14, 1'b0, 32'h0, q); chk(q, 32'h0);
      wb_sel_i <= 4'h2;
      wb(`ITT_REG_SEQCTL, 1'b1, 32'h0701, q);
      wb_sel_i <= 4'hF;
      wb(`ITT_REG_SEQCTL, 1'b0, 32'h0, q); chk(q, 32'h0700);
      wb(`ITT_REG_CTRL, 1'b1, 32'h1, q);
      $display("test regs done");
    end
  endtask
  // Byte from lane 1 to lane 2, irq after every entry
  task t_normal;
    begin
      u_itt_mem_model.mem[0] = 32'h44332211;
      ent(10'h220, 32'h230, 32'h001, 32'h102, 32'h3);
      fire(2);
      chk(rd(10'h100), 32'h00220000);
      chk(rd(10'h224), 32'h002);
      chk(rd(10'h228), 32'h103);
      chk(rd(10'h22C) & 32'hFFFF, 32'h2);
      chk(evt_n - e0, 1);
      chk(evt_chan_o, 32'h2);
      chk(irq_n - i0, 1);
      $display("test normal done");
    end
  endtask
  // Four longwords in one activation, slow memory
  task t_block;
    integer k;
    begin
      mwait <= 4'h3;
      for (k = 0; k < 4; k = k + 1) u_itt_mem_model.mem[4 + k] = 32'hA0 + k;
      ent(10'h230, 32'h3A, 32'h010, 32'h120, 32'h00040001);
      fire(3);
      for (k = 0; k < 4; k = k + 1) chk(rd(10'h120 + 4 * k), 32'hA0 + k);
      chk(rd(10'h234), 32'h020);
      chk(rd(10'h23C) & 32'hFFFF, 32'h0);
      chk(evt_n - e0, 1);
      chk(irq_n - i0, 1);
      mwait <= 4'h0;
      $display("test block done");
    end
  endtask
  // Repeat size 2 on the destination: address returns after two
  task t_repeat;
    begin
      u_itt_mem_model.mem[2] = 32'hBBBBAAAA;
      ent(10'h240, 32'h65, 32'h008, 32'h140, 32'h00020002);
      fire(4);
      chk(irq_n - i0, 0);
      chk(rd(10'h248), 32'h142);
      fire(4);
      chk(rd(10'h248), 32'h140);
      chk(rd(10'h140), 32'hAAAAAAAA);
      chk(irq_n - i0, 1);
      $display("test repeat done");
    end
  endtask
  // Two linked entries on one request
  task t_chain;
    begin
      u_itt_mem_model.mem[12] = 32'h5A5A0001;
      u_itt_mem_model.mem[13] = 32'h5A5A0002;
      ent(10'h250, 32'h88, 32'h030, 32'h160, 32'h5);
      ent(10'h260, 32'h08, 32'h034, 32'h164, 32'h5);
      fire(5);
      chk(rd(10'h160), 32'h5A5A0001);
      chk(rd(10'h164), 32'h5A5A0002);
      chk(evt_n - e0, 2);
      $display("test chain done");
    end
  endtask
  // Selector byte 255 picks the last pointer; division stops after one
  task t_seq;
    begin
      u_itt_mem_model.mem[14] = 32'h000000FF;
      u_itt_mem_model.mem[15] = 32'h13572468;
      u_itt_mem_model.mem[191] = 32'h280;
      ent(10'h270, 32'h000, 32'h038, 32'h170, 32'h5);
      ent(10'h280, 32'h488, 32'h03C, 32'h174, 32'h5);
      ent(10'h290, 32'h008, 32'h03C, 32'h178, 32'h5);
      wb(`ITT_REG_SEQBASE, 1'b1, 32'h300, q);
      wb(`ITT_REG_SEQCTL, 1'b1, 32'h0701, q);
      fire(7);
      chk(rd(10'h170), 32'hFF);
      chk(rd(10'h174), 32'h13572468);
      chk(rd(10'h178), 32'h0);
      chk(q, 32'h00010700);
      fire(7);
      chk(rd(10'h178), 32'h13572468);
      chk(rd(10'h27C) & 32'hFFFF, 32'h4);
      chk(q, 32'h00000700);
      $display("test sequence done");
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial begin
    for (e0 = 0; e0 < 256; e0 = e0 + 1) u_itt_mem_model.mem[e0] = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs; t_normal; t_block; t_repeat; t_chain; t_seq;
    end_sim;
  end
  // Watchdog: all tests need far fewer than 20000 cycles
  initial begin
    #100000;
    fails = fails + 1;
    end_sim;
  end
endmodule
`default_nettype wire
